// [rcfi_pkg.sv]
// Purpose: shared constants, types and helpers for the regulator control block
// Assumes: 250 MHz system clock, seven channels (three converters, four linear)
// Notes: analogue regulation lives outside; this holds only digital control
package rcfi_pkg;
  localparam int NUM_BUCK = 3;
  localparam int NUM_LDO = 4;
  localparam int NUM_CHAN = NUM_BUCK + NUM_LDO;
  // Clock rate and turn-on delay base unit
  localparam int CLK_FREQ_KHZ = 250_000;
  localparam int TURN_ON_BASE_MS = 1;
  localparam int MS_CYCLES = TURN_ON_BASE_MS * CLK_FREQ_KHZ;
  // Power-good drop below target, in percent
  localparam int PG_DROP_BUCK_PCT = 7;
  localparam int PG_DROP_LDO_PCT = 11;
  // Linear regulator power-up voltage code (plain default)
  localparam logic [5:0] LDO_VCODE_RST = 6'h39;
  localparam logic IRQ_N_RST = 1'b1;
  // Voltage code fields
  localparam int VCODE_BASE_MSB = 5;
  localparam int VCODE_BASE_LSB = 3;
  localparam int VCODE_STEP_MSB = 2;

  typedef enum logic [1:0] {RCFI_OFF, RCFI_WAIT, RCFI_ON} rcfi_phase_t;

  // Software-side configuration bits
  typedef struct packed {
    logic [NUM_CHAN-1:0] on_bit;
    logic [NUM_CHAN-1:0][2:0] delay_code;
    logic [NUM_BUCK-1:0][5:0] vout_code_a;
    logic [NUM_BUCK-1:0][5:0] vout_code_b;
    logic [NUM_BUCK-1:0] force_pwm;
    logic [NUM_LDO-1:0] output_discharge_en;
    logic [NUM_LDO-1:0] low_quiescent_en;
    logic [NUM_CHAN-1:0] fault_irq_unmask;
  } rcfi_cfg_t;

  // Controls toward the analogue channels and status toward software
  typedef struct packed {
    logic [NUM_CHAN-1:0] reg_run;
    logic [NUM_CHAN-1:0][5:0] vout_select_code;
    logic [NUM_CHAN-1:0][11:0] vout_mv;
    logic [NUM_CHAN-1:0][11:0] pg_thresh_mv;
    logic [NUM_BUCK-1:0] pwm_forced;
    logic [NUM_LDO-1:0] discharge_on;
    logic [NUM_LDO-1:0] low_q_on;
    logic [NUM_CHAN-1:0] power_good;
  } rcfi_out_t;

  typedef struct packed {
    rcfi_phase_t [NUM_CHAN-1:0] phase;
    logic [NUM_CHAN-1:0][31:0] cnt;
    logic [NUM_CHAN-1:0] en_prev;
    logic [NUM_CHAN-1:0] pg_s1;
    logic [NUM_CHAN-1:0] pg_s2;
    logic bank_s1;
    logic bank_s2;
    logic [NUM_CHAN-1:0] fault;
    logic [NUM_LDO-1:0][5:0] ldo_code;
    logic irq_n_out;
    rcfi_out_t out;
  } rcfi_state_t;

  // Voltage code to millivolts
  function automatic logic [11:0] code_to_mv(input logic [5:0] code);
    logic [11:0] base;
    logic [11:0] step;
    base = 12'h000;
    step = 12'h000;
    case (code[VCODE_BASE_MSB:VCODE_BASE_LSB])
      3'h0: base = 12'd600;
      3'h1: base = 12'd800;
      3'h2: base = 12'd1000;
      3'h3: base = 12'd1200;
      3'h4: base = 12'd1600;
      3'h5: base = 12'd2000;
      3'h6: base = 12'd2400;
      default: base = 12'd3200;
    endcase
    if (code[VCODE_BASE_MSB:VCODE_BASE_LSB] < 3'h3) begin
      step = 12'd25;
    end else if (code[VCODE_BASE_MSB:VCODE_BASE_LSB] < 3'h6) begin
      step = 12'd50;
    end else begin
      step = 12'd100;
    end
    return 12'(base + step * {9'h000, code[VCODE_STEP_MSB:0]});
  endfunction

  // Delay code to cycles: 0 or 2^code ms
  function automatic logic [31:0] delay_cycles(input logic [2:0] code, input int ms_cyc);
    logic [31:0] ms;
    ms = 32'(1) << code;
    return (code == 3'h0) ? 32'h0000_0000 : 32'(ms * 32'(ms_cyc));
  endfunction

  // Threshold sitting pct percent under the target
  function automatic logic [11:0] pg_thresh(input logic [11:0] mv, input int pct);
    return 12'((32'(mv) * 32'(100 - pct)) / 32'(100));
  endfunction
endpackage

// [rcfi_ctrl.sv]
// Contract
// RULE_01: Converter runs auto power-save by default; mode bit 1 forces PWM.
// RULE_02: Converter power-good flag reads 0 while output sits under 7% threshold.
// RULE_03: Unmasked converter under threshold drives interrupt line low.
// RULE_04: Interrupt holds until channel off or regulating and its flag read.
// RULE_05: Six-bit code maps base voltages and 25/50/100 mV steps to 3.900.
// RULE_06: Linear regulators start at default code; software may rewrite it later.
// RULE_07: Linear regulator switches only on enable edges; steady level does nothing.
// RULE_08: Software writes 0 then 1 to enable, 1 then 0 to disable.
// RULE_09: Linear regulator waits its programmed delay before starting output.
// RULE_10: Discharge bit 1 grounds output through resistor while disabled.
// RULE_11: Low-quiescent bit 1 puts linear regulator in reduced-current mode.
// RULE_12: Linear regulator power-good flag reads 0 under 11% threshold.
// RULE_13: Unmasked linear regulator fault asserts interrupt, cleared like converters.
// RULE_14: Delay codes give 0,2,4,8,16,32,64,128 ms.
// RULE_15: Converter uses code A with bank pin low, code B with it high.
// RULE_16: Converters have their own delay field with the same encoding.
// RULE_17: Interrupt output is active-low OR of all latched unmasked faults.
// RULE_18: Fault latch clears only if off or regulating when flag read.
//
// Purpose: enable sequencing, voltage selection and fault interrupt for seven channels
// Assumes: power-good comparators and bank pin are asynchronous; cfg and reads on clk_sys
// Notes: channels 0..2 are converters, 3..6 linear regulators
`timescale 1ns/100ps
module rcfi_ctrl #(
  parameter int MS_CYC = rcfi_pkg::MS_CYCLES
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire rcfi_pkg::rcfi_cfg_t cfg, // Software configuration bits
  input wire logic [3:0] ldo_code_wr, // Write pulse per linear regulator code
  input wire logic [5:0] ldo_code_wdata, // Code written with the pulse
  input wire logic [6:0] ok_read, // Power-good flag read pulse per channel
  input wire logic [6:0] pg_ok_pin, // Raw power-good comparators
  input wire logic vout_bank_pin, // Converter code bank select pin
  output rcfi_pkg::rcfi_out_t ctl, // Channel controls and status
  output logic irq_n_out // Fault interrupt, active low
);
  rcfi_pkg::rcfi_state_t q;
  rcfi_pkg::rcfi_state_t next_q;
  logic [6:0] rise;
  logic [6:0] fall;
  logic [6:0] fault_set;

  // Enable edges and fault causes, from current state
  always_comb begin
    for (int i = 0; i < rcfi_pkg::NUM_CHAN; i++) begin
      rise[i] = cfg.on_bit[i] & ~q.en_prev[i];
      fall[i] = ~cfg.on_bit[i] & q.en_prev[i];
      // RULE_03 RULE_13: unmasked sag while on
      fault_set[i] = cfg.fault_irq_unmask[i] & (q.phase[i] == rcfi_pkg::RCFI_ON) & ~q.pg_s2[i];
    end
  end

  // Next state of the whole block
  always_comb begin
    next_q = q;
    // Two-stage synchronisers; only stage two feeds logic
    next_q.pg_s1 = pg_ok_pin;
    next_q.pg_s2 = q.pg_s1;
    next_q.bank_s1 = vout_bank_pin;
    next_q.bank_s2 = q.bank_s1;
    next_q.en_prev = cfg.on_bit;
    // RULE_06: rewritable code
    for (int j = 0; j < rcfi_pkg::NUM_LDO; j++) begin
      if (ldo_code_wr[j]) begin
        next_q.ldo_code[j] = ldo_code_wdata;
      end
    end
    for (int i = 0; i < rcfi_pkg::NUM_CHAN; i++) begin
      // RULE_07: edge-driven switching
      // RULE_09: turn-on wait
      // RULE_16: converters share it
      case (q.phase[i])
        rcfi_pkg::RCFI_OFF: begin
          if (rise[i]) begin
            next_q.phase[i] = rcfi_pkg::RCFI_WAIT;
            // RULE_14: delay encoding
            next_q.cnt[i] = rcfi_pkg::delay_cycles(cfg.delay_code[i], MS_CYC);
          end
        end
        rcfi_pkg::RCFI_WAIT: begin
          if (fall[i]) begin
            next_q.phase[i] = rcfi_pkg::RCFI_OFF;
          end else if (q.cnt[i] == 32'h0000_0000) begin
            next_q.phase[i] = rcfi_pkg::RCFI_ON;
          end else begin
            next_q.cnt[i] = q.cnt[i] - 32'h0000_0001;
          end
        end
        rcfi_pkg::RCFI_ON: begin
          if (fall[i]) begin
            next_q.phase[i] = rcfi_pkg::RCFI_OFF;
          end
        end
        default: next_q.phase[i] = rcfi_pkg::RCFI_OFF;
      endcase
      next_q.out.reg_run[i] = (next_q.phase[i] == rcfi_pkg::RCFI_ON);
      // RULE_04: latch holds until read
      // RULE_18: set beats clear; clear only when off or regulating
      if (fault_set[i]) begin
        next_q.fault[i] = 1'b1;
      end else if (ok_read[i] && ((q.phase[i] != rcfi_pkg::RCFI_ON) || q.pg_s2[i])) begin
        next_q.fault[i] = 1'b0;
      end
      // RULE_02: flag follows comparator
      // RULE_12: same for linear
      next_q.out.power_good[i] = q.pg_s2[i];
    end
    // RULE_15: bank select
    for (int b = 0; b < rcfi_pkg::NUM_BUCK; b++) begin
      next_q.out.vout_select_code[b] = q.bank_s2 ? cfg.vout_code_b[b] : cfg.vout_code_a[b];
    end
    for (int j = 0; j < rcfi_pkg::NUM_LDO; j++) begin
      next_q.out.vout_select_code[j + rcfi_pkg::NUM_BUCK] = q.ldo_code[j];
      // RULE_10: discharge only while not running
      next_q.out.discharge_on[j] = cfg.output_discharge_en[j] &
        (q.phase[j + rcfi_pkg::NUM_BUCK] != rcfi_pkg::RCFI_ON);
      // RULE_11: reduced-current mode
      next_q.out.low_q_on[j] = cfg.low_quiescent_en[j];
    end
    // RULE_05: code to millivolts, plus threshold for the comparator trim
    for (int i = 0; i < rcfi_pkg::NUM_CHAN; i++) begin
      next_q.out.vout_mv[i] = rcfi_pkg::code_to_mv(q.out.vout_select_code[i]);
      next_q.out.pg_thresh_mv[i] = rcfi_pkg::pg_thresh(q.out.vout_mv[i],
        (i < rcfi_pkg::NUM_BUCK) ? rcfi_pkg::PG_DROP_BUCK_PCT : rcfi_pkg::PG_DROP_LDO_PCT);
    end
    // RULE_01: forced PWM else auto power-save
    next_q.out.pwm_forced = cfg.force_pwm;
    // RULE_17: any pending fault pulls the line low
    next_q.irq_n_out = ~|next_q.fault;
  end

  // State register; reset values are constants only
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= '0;
      q.irq_n_out <= rcfi_pkg::IRQ_N_RST;
      q.ldo_code <= {rcfi_pkg::NUM_LDO{rcfi_pkg::LDO_VCODE_RST}};
    end else begin
      q <= next_q;
    end
  end

  assign ctl = q.out;
  assign irq_n_out = q.irq_n_out;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  pwm_mode_follow_a: assert property (##1 ctl.pwm_forced == $past(cfg.force_pwm)) // RULE_01
    else $error("pwm mode does not follow mode bit");
  irq_or_faults_a: assert property (irq_n_out == ~|q.fault) // RULE_17
    else $error("interrupt line disagrees with fault latches");
  code_map_top_a: assert property ( // RULE_05
    ctl.vout_select_code[3] == 6'h3f |=> ctl.vout_mv[3] == 12'd3900)
    else $error("top voltage code not 3900 mV");
  code_map_base_a: assert property ( // RULE_05
    ctl.vout_select_code[4] == 6'h00 |=> ctl.vout_mv[4] == 12'd600)
    else $error("bottom voltage code not 600 mV");
  low_q_follow_a: assert property (##1 ctl.low_q_on == $past(cfg.low_quiescent_en)) // RULE_11
    else $error("reduced-current mode does not follow its bit");
  irq_hold_read_a: assert property (!irq_n_out && ok_read == 7'h00 |=> !irq_n_out) // RULE_04
    else $error("interrupt released without a flag read");

  for (genvar g = 0; g < rcfi_pkg::NUM_CHAN; g++) begin : g_chk
    // RULE_03 and RULE_13 checked here
    fault_raise_irq_a: assert property (fault_set[g] |=> q.fault[g] && !irq_n_out) // RULE_03
      else $error("unmasked fault did not pull interrupt low");
    fault_hold_read_a: assert property (q.fault[g] && !ok_read[g] |=> q.fault[g]) // RULE_04
      else $error("fault dropped without a flag read");
    fault_clear_ok_a: assert property ( // RULE_18
      q.fault[g] && ok_read[g] && !fault_set[g]
      && (q.phase[g] != rcfi_pkg::RCFI_ON || q.pg_s2[g]) |=> !q.fault[g])
      else $error("fault not cleared by read once regulating or off");
    off_steady_a: assert property ( // RULE_07
      q.phase[g] == rcfi_pkg::RCFI_OFF && !rise[g]
      |=> q.phase[g] == rcfi_pkg::RCFI_OFF && !ctl.reg_run[g])
      else $error("channel left off without a rising enable");
    on_steady_a: assert property ( // RULE_07
      q.phase[g] == rcfi_pkg::RCFI_ON && !fall[g] |=> ctl.reg_run[g])
      else $error("channel dropped without a falling enable");
    delay_load_a: assert property ( // RULE_14
      q.phase[g] == rcfi_pkg::RCFI_OFF && rise[g]
      |=> q.phase[g] == rcfi_pkg::RCFI_WAIT
      && q.cnt[g] == rcfi_pkg::delay_cycles($past(cfg.delay_code[g]), MS_CYC))
      else $error("turn-on delay loaded wrong");
    delay_count_a: assert property ( // RULE_09
      q.phase[g] == rcfi_pkg::RCFI_WAIT && !fall[g]
      && q.cnt[g] != 32'h0000_0000 |=> q.cnt[g] == $past(q.cnt[g]) - 32'h0000_0001
      && !ctl.reg_run[g])
      else $error("channel started before its delay ran out");
    pg_flag_low_a: assert property (!q.pg_s2[g] |=> !ctl.power_good[g]) // RULE_12
      else $error("power-good flag high under threshold");
  end

  for (genvar b = 0; b < rcfi_pkg::NUM_BUCK; b++) begin : g_bank
    bank_pick_a: assert property ( // RULE_15
      ##1 ctl.vout_select_code[b] ==
      ($past(q.bank_s2) ? $past(cfg.vout_code_b[b]) : $past(cfg.vout_code_a[b])))
      else $error("converter code taken from wrong bank");
  end

  for (genvar m = 0; m < rcfi_pkg::NUM_LDO; m++) begin : g_ldo
    // Code writes and idle discharge on each linear channel
    ldo_code_write_a: assert property ( // RULE_06
      ldo_code_wr[m] |=> q.ldo_code[m] == $past(ldo_code_wdata))
      else $error("linear code write not taken");
    discharge_idle_a: assert property ( // RULE_10
      q.phase[m + 3] == rcfi_pkg::RCFI_OFF && cfg.output_discharge_en[m] |=> ctl.discharge_on[m])
      else $error("discharge missing while regulator off");
  end

  discharge_off_a: assert property ( // RULE_10
    q.phase[3] == rcfi_pkg::RCFI_ON |=> !ctl.discharge_on[0])
    else $error("discharge applied while regulator running");

  // Main scenarios worth seeing once
  fault_then_clear_c: cover property (q.fault[0] ##[1:20] !q.fault[0]);
  ldo_comes_up_c: cover property (rise[3] ##[1:40] ctl.reg_run[3]);
  bank_switch_c: cover property (!q.bank_s2 ##1 q.bank_s2);
  irq_release_c: cover property (!irq_n_out ##1 irq_n_out);
endmodule

// [rcfi_chan_model.sv]
// Purpose: stand-in for the seven analogue rails and their comparators
// Assumes: a rail sits in regulation only while its channel runs
// Notes: fault_inj pulls a rail under threshold on command
`timescale 1ns/100ps
module rcfi_chan_model (
  input wire logic [6:0] reg_run, // Channel running
  input wire logic [6:0] fault_inj, // Commanded rail sag
  output logic [6:0] pg_ok_pin // Comparator outputs
);
  // rail above threshold
  // Off rails read low, so software unmasks only after power-up
  assign pg_ok_pin = reg_run & ~fault_inj;
endmodule

// [rcfi_ctrl_tb_top.sv]
// Purpose: self-checking bench for the regulator control block
// Assumes: MS_CYC cut to 4 cycles so delays stay short
// Notes: run and interrupt changes are matched against timed notes
`timescale 1ns/100ps
module rcfi_ctrl_tb_top;
  localparam int MSC = 4;
  typedef struct {int c; logic [7:0] v;} rcfi_note_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  rcfi_pkg::rcfi_cfg_t cfg = '0;
  logic [3:0] ldo_code_wr = '0;
  logic [5:0] ldo_code_wdata = '0;
  logic [6:0] ok_read = '0;
  logic [6:0] fault_inj = '0;
  logic [6:0] pg_ok_pin;
  logic vout_bank_pin = 1'b0;
  rcfi_pkg::rcfi_out_t ctl;
  logic irq_n_out;
  int cyc = 0;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] ev = 8'h80;
  logic [7:0] pv = 8'h80;
  logic [5:0] c;
  rcfi_note_t q[$];
  rcfi_note_t n;

  rcfi_ctrl #(.MS_CYC(MSC)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg),
    .ldo_code_wr(ldo_code_wr), .ldo_code_wdata(ldo_code_wdata), .ok_read(ok_read),
    .pg_ok_pin(pg_ok_pin), .vout_bank_pin(vout_bank_pin), .ctl(ctl), .irq_n_out(irq_n_out));
  rcfi_chan_model u_rails (.reg_run(ctl.reg_run), .fault_inj(fault_inj), .pg_ok_pin(pg_ok_pin));

  // Clock, 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // Edge count, read before its update by every process
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Independent voltage table, in mV
  function automatic int mv(logic [5:0] k);
    int b[8] = '{600, 800, 1000, 1200, 1600, 2000, 2400, 3200};
    int s;
    s = (k[5:3] < 3) ? 25 : (k[5:3] < 6) ? 50 : 100;
    return b[k[5:3]] + s * k[2:0];
  endfunction
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic note(int dc, int b, logic v);
    ev[b] = v;
    q.push_back('{cyc + dc, ev});
  endtask
  // edge-only enable writes
  // On and off go through 0-then-1 and 1-then-0 writes only
  task automatic en(int ch, logic v, int d);
    @(posedge clk_sys);
    cfg.on_bit[ch] <= v;
    note(v ? d + 3 : 2, ch, v);
  endtask
  task automatic sag(int ch, logic v);
    @(posedge clk_sys);
    fault_inj[ch] <= v;
  endtask
  task automatic rd(int ch, logic clr);
    @(posedge clk_sys);
    ok_read[ch] <= 1'b1;
    if (clr) note(2, 7, 1'b1);
    @(posedge clk_sys);
    ok_read[ch] <= 1'b0;
  endtask
  // Bounded wait until every note has been met
  task automatic drain();
    for (int i = 0; i < 2000 && q.size() > 0; i++) tick(1);
    if (q.size() > 0) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // Each change on the run and interrupt lines takes the oldest note
  always @(posedge clk_sys) begin
    if (reset_n && {irq_n_out, ctl.reg_run} !== pv) begin
      pv = {irq_n_out, ctl.reg_run};
      if (q.size() == 0) begin
        chk("run_irq", pv, ev);
      end else begin
        n = q.pop_front();
        chk("run_irq", pv, n.v);
        chk("event_cycle", cyc, n.c);
      end
    end
  end

  initial begin
    void'($urandom(32'hecf24ee8));
    tick(5);
    reset_n <= 1'b1;
    tick(3);
    chk("pwm_default", ctl.pwm_forced, 0);
    chk("ldo_rst_code", ctl.vout_select_code[3], 6'h39);
    cfg.force_pwm <= 3'($urandom);
    cfg.low_quiescent_en <= 4'($urandom);
    cfg.output_discharge_en <= 4'hF;
    tick(3);
    chk("pwm", ctl.pwm_forced, cfg.force_pwm);
    chk("low_q", ctl.low_q_on, cfg.low_quiescent_en);
    chk("discharge_off", ctl.discharge_on, 4'hF);
    // Every delay code, spread over the channels; a steady high does nothing
    for (int k = 0; k < 8; k++) begin
      cfg.delay_code[k % 7] <= 3'(k);
      en(k % 7, 1'b1, (k == 0) ? 0 : (1 << k) * MSC);
      drain();
      tick(5);
      chk("discharge_run", ctl.discharge_on,
        (k % 7 > 2) ? 4'hF & ~(4'h1 << (k % 7 - 3)) : 4'hF);
      en(k % 7, 1'b0, 0);
      drain();
    end
    // Linear codes: both ends of the range, then random
    for (int j = 0; j < 4; j++) begin
      c = (j == 0) ? 6'h3F : (j == 1) ? 6'h00 : 6'($urandom);
      ldo_code_wr[j] <= 1'b1;
      ldo_code_wdata <= c;
      tick(1);
      ldo_code_wr[j] <= 1'b0;
      tick(5);
      chk("ldo_code", ctl.vout_select_code[3 + j], c);
      chk("ldo_mv", ctl.vout_mv[3 + j], mv(c));
      chk("ldo_pg_mv", ctl.pg_thresh_mv[3 + j], mv(c) * 89 / 100);
    end
    // Converter bank select
    cfg.vout_code_a[0] <= 6'($urandom);
    cfg.vout_code_b[0] <= 6'($urandom);
    tick(6);
    chk("bank_a", ctl.vout_mv[0], mv(cfg.vout_code_a[0]));
    chk("buck_pg_mv", ctl.pg_thresh_mv[0], mv(cfg.vout_code_a[0]) * 93 / 100);
    vout_bank_pin <= 1'b1;
    tick(6);
    chk("bank_b", ctl.vout_mv[0], mv(cfg.vout_code_b[0]));
    // Two faults; a read during the fault leaves the latch set
    cfg.delay_code[0] <= 3'h0;
    cfg.delay_code[4] <= 3'h0;
    en(0, 1'b1, 0);
    en(4, 1'b1, 0);
    drain();
    // Synchronised good flags lag the rails; unmask only once they read high
    tick(3);
    cfg.fault_irq_unmask <= 7'h11;
    sag(0, 1'b1);
    note(4, 7, 1'b0);
    drain();
    chk("pg_low", ctl.power_good[0], 0);
    rd(0, 1'b0);
    sag(4, 1'b1);
    tick(6);
    chk("pg_low_ldo", ctl.power_good[4], 0);
    sag(0, 1'b0);
    tick(6);
    chk("pg_high", ctl.power_good[0], 1);
    rd(0, 1'b0);
    tick(4);
    en(4, 1'b0, 0);
    drain();
    rd(4, 1'b1);
    sag(4, 1'b0);
    en(0, 1'b0, 0);
    drain();
    tick(4);
    wrap_up();
  end
endmodule
